// >>> logic/stmr_pkg.sv
package stmr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int BUS_W      = 32;
  localparam int BYTE_W     = 8;
  localparam int CNT_W      = 16;
  localparam int OFS_W      = 8;
  localparam int PRESCALE_W = 6;
  localparam int PIN_COUNT  = 3;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [OFS_W-1:0] OFS_RUN_CLOCK   = 8'h00;
  localparam logic [OFS_W-1:0] OFS_MODE_OUTPUT = 8'h04;
  localparam logic [OFS_W-1:0] OFS_COUNT_LOW   = 8'h08;
  localparam logic [OFS_W-1:0] OFS_COUNT_HIGH  = 8'h0c;
  localparam logic [OFS_W-1:0] OFS_MATCH_LOW   = 8'h10;
  localparam logic [OFS_W-1:0] OFS_MATCH_HIGH  = 8'h14;
  localparam logic [OFS_W-1:0] OFS_PERIOD      = 8'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int PAUSE_BIT     = 7;
  localparam int CLKSEL_MSB    = 6;
  localparam int CLKSEL_LSB    = 4;
  localparam int RUN_BIT       = 3;
  localparam int MODE_MSB      = 7;
  localparam int MODE_LSB      = 6;
  localparam int PINFN_MSB     = 5;
  localparam int PINFN_LSB     = 4;
  localparam int OUTCTL_BIT    = 3;
  localparam int POLARITY_BIT  = 2;
  localparam int SWAP_BIT      = 1;
  localparam int CLRSEL_BIT    = 0;
  localparam logic [BYTE_W-1:0] CTRL_RESET  = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_RESET  = 8'h00;
  localparam logic [CNT_W-1:0]  COUNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0]  COUNT_MAX   = 16'hffff;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;
  localparam logic [1:0] PF_HOLD      = 2'h0;
  localparam logic [1:0] PF_LOW       = 2'h1;
  localparam logic [1:0] PF_HIGH      = 2'h2;
  localparam logic [1:0] PF_TOGGLE    = 2'h3;
  localparam logic [1:0] PF_INACTIVE  = 2'h0;
  localparam logic [1:0] PF_ACTIVE    = 2'h1;
  localparam logic [1:0] PF_WAVE      = 2'h2;
  localparam logic [1:0] PF_SINGLE    = 2'h3;
  localparam logic [1:0] CAP_RISE     = 2'h0;
  localparam logic [1:0] CAP_FALL     = 2'h1;
  localparam logic [1:0] CAP_BOTH     = 2'h2;
  localparam logic [2:0] CK_SYS_DIV4  = 3'h0;
  localparam logic [2:0] CK_SYS       = 3'h1;
  localparam logic [2:0] CK_HI_DIV16  = 3'h2;
  localparam logic [2:0] CK_HI_DIV64  = 3'h3;
  localparam logic [2:0] CK_SUB_A     = 3'h4;
  localparam logic [2:0] CK_SUB_B     = 3'h5;
  localparam logic [2:0] CK_EXT_RISE  = 3'h6;
  localparam logic [2:0] CK_EXT_FALL  = 3'h7;

  // ----------------------------------------------------------------
  // Prescaler masks, pin indices, bus codes
  // ----------------------------------------------------------------
  localparam logic [PRESCALE_W-1:0] DIV4_MASK  = 6'h03;
  localparam logic [PRESCALE_W-1:0] DIV16_MASK = 6'h0f;
  localparam logic [PRESCALE_W-1:0] DIV64_MASK = 6'h3f;
  localparam int PIN_EXT = 0;
  localparam int PIN_CAP = 1;
  localparam int PIN_SUB = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage : stmr_pkg

// >>> logic/stmr_clk_if.sv
`timescale 1ns/1ps
interface stmr_clk_if;
  logic [2:0] clkSel;
  logic       runEnable;
  logic       extRise;
  logic       extFall;
  logic       subRise;
  logic       countTick;

  // Timer core drives the selection, source answers with ticks
  modport core (output clkSel, output runEnable, output extRise, output extFall,
                output subRise, input countTick);
  modport src  (input clkSel, input runEnable, input extRise, input extFall,
                input subRise, output countTick);
endinterface : stmr_clk_if

// >>> logic/stmr_pin_sync.sv
`timescale 1ns/1ps
module stmr_pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Raw pins and their edges
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinRise,
  output logic      [WIDTH-1:0] pinFall
);
  logic [WIDTH-1:0] syncFirst;
  logic [WIDTH-1:0] syncSecond;
  logic [WIDTH-1:0] syncPrev;

  // Two-stage synchroniser plus one history stage
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncFirst  <= '0;
      syncSecond <= '0;
      syncPrev   <= '0;
    end else begin
      syncFirst  <= pinIn;
      syncSecond <= syncFirst;
      syncPrev   <= syncSecond;
    end
  end

  // Edges seen only past the second stage
  assign pinRise = syncSecond & ~syncPrev;
  assign pinFall = ~syncSecond & syncPrev;
endmodule : stmr_pin_sync

// >>> logic/stmr_clock_select.sv
`timescale 1ns/1ps
module stmr_clock_select (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Tick selection
  stmr_clk_if.src   clk
);
  import stmr_pkg::*;

  logic [PRESCALE_W-1:0] prescale;

  function automatic logic wrapAt(input logic [PRESCALE_W-1:0] value,
                                  input logic [PRESCALE_W-1:0] mask);
    wrapAt = ((value & mask) == mask);
  endfunction : wrapAt

  // Free prescaler, held at zero while powered down
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescale <= '0;
    end else if (!clk.runEnable) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 6'h01;
    end
  end

  // Source selection
  always_comb begin
    unique case (clk.clkSel)
      CK_SYS_DIV4: clk.countTick = wrapAt(prescale, DIV4_MASK);
      CK_SYS:      clk.countTick = 1'b1;
      CK_HI_DIV16: clk.countTick = wrapAt(prescale, DIV16_MASK);
      CK_HI_DIV64: clk.countTick = wrapAt(prescale, DIV64_MASK);
      CK_SUB_A:    clk.countTick = clk.subRise;
      CK_SUB_B:    clk.countTick = clk.subRise;
      CK_EXT_RISE: clk.countTick = clk.extRise;
      CK_EXT_FALL: clk.countTick = clk.extFall;
    endcase
  end
endmodule : stmr_clock_select

// >>> logic/stmr_top.sv
// Operation
// - 16-bit up-counter advancing on each tick of the selected clock source.
// - Period byte compares top counter byte; match A compares all sixteen bits.
// - Software cannot write the counter; software clears it only by a run-enable rise.
// - Overflow or selected comparator match clears counter and raises its flag.
// - Counter is a read-only byte pair; match A read/write pair; period one byte.
// - Pause freezes the counter; clearing pause resumes from held value.
// - Three-bit clock select picks divided system, sub, or external pin edges.
// - Run-enable set runs the counter; clear stops it and powers down.
// - Run-enable rise zeroes the counter; fall holds its value.
// - Run-enable rise returns output pin to the output-control level.
// - Low three bits of the run/clock register read as zero.
// - Mode: 00 compare, 01 capture, 10 PWM/single pulse, 11 timer.
// - Output pin level is not meaningful in timer/counter mode.
// - Compare mode pin function on match A: hold, low, high, toggle.
// - PWM pin function: inactive, active, waveform, single pulse.
// - Three input pins, external clock, capture and sub clock; two driven output pins.
// - In compare and timer modes, clear select 1 clears on match A, 0 on period match or overflow.
// - Output control gives compare initial level, or PWM active level.
// - Polarity bit inverts the output pin, except in timer mode.
// - Period 1..255 matches every value times 256 ticks; 0 overflows at 65536.
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module stmr_top (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [stmr_pkg::BUS_W-1:0]  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [stmr_pkg::BUS_W-1:0]  hwdata,
  input  wire logic                        hready,
  output logic      [stmr_pkg::BUS_W-1:0]  hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // Timer pins
  input  wire logic                        externalClockPin,
  input  wire logic                        capturePin,
  input  wire logic                        subClockPin,
  output logic                             timerOutputPin,
  output logic                             timerOutputPinInv,
  // Match events
  output logic                             matchAFlag,
  output logic                             periodMatchFlag
);
  import stmr_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                   phaseWrite;
  logic [OFS_W-1:0]       phaseAddr;
  logic                   writeStrobe;
  logic [BYTE_W-1:0]      writeByte;
  logic [BYTE_W-1:0]      readByte;
  logic                   pauseBit;
  logic [2:0]             clockSelect;
  logic                   runEnable;
  logic                   runPrev;
  logic                   runRise;
  logic [BYTE_W-1:0]      modeControl;
  logic [1:0]             modeField;
  logic [1:0]             pinFunction;
  logic                   outputControl;
  logic                   polarityBit;
  logic                   swapBit;
  logic                   clearSelect;
  logic [CNT_W-1:0]       matchAValue;
  logic [BYTE_W-1:0]      periodValue;
  logic [CNT_W-1:0]       count;
  logic [CNT_W-1:0]       countInc;
  logic                   counting;
  logic                   matchAHit;
  logic                   periodHit;
  logic                   overflowHit;
  logic                   clearOnMatchA;
  logic                   counterClear;
  logic                   captureEdge;
  logic                   captureNow;
  logic                   matchAEvent;
  logic                   periodEvent;
  logic                   compareLevel;
  logic                   pulseOn;
  logic                   pwmActive;
  logic                   next_pinLevel;
  logic [PIN_COUNT-1:0]   pinRise;
  logic [PIN_COUNT-1:0]   pinFall;

  stmr_clk_if clkIf ();

  // ----------------------------------------------------------------
  // Pin synchronisers and tick source
  // ----------------------------------------------------------------
  stmr_pin_sync #(
    .WIDTH   (PIN_COUNT)
  ) u_pin_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pinIn    ({subClockPin, capturePin, externalClockPin}),
    .pinRise  (pinRise),
    .pinFall  (pinFall)
  );

  // Feed the selection and pin edges to the tick source
  assign clkIf.clkSel    = clockSelect;
  assign clkIf.runEnable = runEnable;
  assign clkIf.extRise   = pinRise[PIN_EXT];
  assign clkIf.extFall   = pinFall[PIN_EXT];
  assign clkIf.subRise   = pinRise[PIN_SUB];

  stmr_clock_select u_clock_select (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk      (clkIf.src)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave, one wait state per transfer
  // ----------------------------------------------------------------
  // Address phase taken while ready, data phase stalls one cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hreadyout  <= 1'b1;
      phaseWrite <= 1'b0;
      phaseAddr  <= '0;
      hrdata     <= '0;
    end else if (hreadyout) begin
      if (hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)) begin
        hreadyout  <= 1'b0;
        phaseWrite <= hwrite;
        phaseAddr  <= haddr[OFS_W-1:0];
      end
    end else begin
      hreadyout <= 1'b1;
      hrdata    <= phaseWrite ? '0 : {{(BUS_W-BYTE_W){1'b0}}, readByte};
    end
  end

  assign hresp       = HRESP_OKAY;
  assign writeStrobe = !hreadyout && phaseWrite;
  assign writeByte   = hwdata[BYTE_W-1:0];

  // Read decode, unmapped addresses read zero
  always_comb begin
    unique case (phaseAddr)
      OFS_RUN_CLOCK:   readByte = {pauseBit, clockSelect, runEnable, 3'h0};
      OFS_MODE_OUTPUT: readByte = modeControl;
      OFS_COUNT_LOW:   readByte = count[BYTE_W-1:0];
      OFS_COUNT_HIGH:  readByte = count[CNT_W-1:BYTE_W];
      OFS_MATCH_LOW:   readByte = matchAValue[BYTE_W-1:0];
      OFS_MATCH_HIGH:  readByte = matchAValue[CNT_W-1:BYTE_W];
      OFS_PERIOD:      readByte = periodValue;
      default:         readByte = BYTE_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Run, pause and clock select
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pauseBit    <= CTRL_RESET[PAUSE_BIT];
      clockSelect <= CTRL_RESET[CLKSEL_MSB:CLKSEL_LSB];
      runEnable   <= CTRL_RESET[RUN_BIT];
    end else if (writeStrobe && phaseAddr == OFS_RUN_CLOCK) begin
      pauseBit    <= writeByte[PAUSE_BIT];
      clockSelect <= writeByte[CLKSEL_MSB:CLKSEL_LSB];
      runEnable   <= writeByte[RUN_BIT];
    end
  end

  // Mode and output control
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      modeControl <= CTRL_RESET;
    end else if (writeStrobe && phaseAddr == OFS_MODE_OUTPUT) begin
      modeControl <= writeByte;
    end
  end

  assign modeField     = modeControl[MODE_MSB:MODE_LSB];
  assign pinFunction   = modeControl[PINFN_MSB:PINFN_LSB];
  assign outputControl = modeControl[OUTCTL_BIT];
  assign polarityBit   = modeControl[POLARITY_BIT];
  assign swapBit       = modeControl[SWAP_BIT];
  assign clearSelect   = modeControl[CLRSEL_BIT];

  // Match A pair, loaded by software or by a capture
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      matchAValue <= COUNT_RESET;
    end else if (captureNow) begin
      matchAValue <= count;
    end else if (writeStrobe && phaseAddr == OFS_MATCH_LOW) begin
      matchAValue[BYTE_W-1:0] <= writeByte;
    end else if (writeStrobe && phaseAddr == OFS_MATCH_HIGH) begin
      matchAValue[CNT_W-1:BYTE_W] <= writeByte;
    end
  end

  // Period byte
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      periodValue <= BYTE_RESET;
    end else if (writeStrobe && phaseAddr == OFS_PERIOD) begin
      periodValue <= writeByte;
    end
  end

  // ----------------------------------------------------------------
  // Counter and comparators
  // ----------------------------------------------------------------
  // Run-enable history for the rising edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      runPrev <= 1'b0;
    end else begin
      runPrev <= runEnable;
    end
  end

  assign runRise     = runEnable && !runPrev;
  assign counting    = runEnable && !pauseBit && clkIf.countTick;
  assign countInc    = count + 16'h0001;
  assign matchAHit   = counting && (countInc == matchAValue)
                       && (matchAValue != COUNT_RESET) && (modeField != MODE_CAPTURE);
  assign periodHit   = counting && (periodValue != BYTE_RESET)
                       && (countInc[CNT_W-1:BYTE_W] == periodValue)
                       && (countInc[BYTE_W-1:0] == BYTE_RESET);
  assign overflowHit = counting && (count == COUNT_MAX) && (periodValue == BYTE_RESET);

  // Clear source per mode
  always_comb begin
    unique case (modeField)
      MODE_COMPARE: clearOnMatchA = clearSelect;
      MODE_TIMER:   clearOnMatchA = clearSelect;
      MODE_PWM:     clearOnMatchA = swapBit;
      MODE_CAPTURE: clearOnMatchA = 1'b0;
    endcase
  end

  assign counterClear = clearOnMatchA ? matchAHit : (periodHit || overflowHit);

  // Counter, only cleared by run rise, match or overflow
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= COUNT_RESET;
    end else if (runRise) begin
      count <= COUNT_RESET;
    end else if (counting) begin
      count <= counterClear ? COUNT_RESET : countInc;
    end
  end

  // ----------------------------------------------------------------
  // Capture and match events
  // ----------------------------------------------------------------
  // Capture edge per pin function
  always_comb begin
    unique case (pinFunction)
      CAP_RISE: captureEdge = pinRise[PIN_CAP];
      CAP_FALL: captureEdge = pinFall[PIN_CAP];
      CAP_BOTH: captureEdge = pinRise[PIN_CAP] || pinFall[PIN_CAP];
      default:  captureEdge = 1'b0;
    endcase
  end

  assign captureNow  = runEnable && (modeField == MODE_CAPTURE) && captureEdge;
  assign matchAEvent = matchAHit || captureNow;
  assign periodEvent = (periodHit || overflowHit)
                       && !(clearSelect && (modeField == MODE_COMPARE
                                            || modeField == MODE_TIMER));

  // Event pulses out
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      matchAFlag      <= 1'b0;
      periodMatchFlag <= 1'b0;
    end else begin
      matchAFlag      <= matchAEvent;
      periodMatchFlag <= periodEvent;
    end
  end

  // ----------------------------------------------------------------
  // Output waveform
  // ----------------------------------------------------------------
  // Compare-mode level, reloaded on run rise
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compareLevel <= 1'b0;
    end else if (runRise) begin
      compareLevel <= outputControl;
    end else if (matchAHit && modeField == MODE_COMPARE) begin
      unique case (pinFunction)
        PF_HOLD:   compareLevel <= compareLevel;
        PF_LOW:    compareLevel <= 1'b0;
        PF_HIGH:   compareLevel <= 1'b1;
        PF_TOGGLE: compareLevel <= !compareLevel;
      endcase
    end
  end

  // Single pulse, active from run rise to the next match A
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulseOn <= 1'b0;
    end else if (runRise) begin
      pulseOn <= 1'b1;
    end else if (matchAHit) begin
      pulseOn <= 1'b0;
    end
  end

  // Duty window, values 100% when duty reaches the period
  assign pwmActive = swapBit ? (count < {periodValue, BYTE_RESET})
                             : (count < matchAValue);

  // Pin level with polarity applied
  always_comb begin
    next_pinLevel = 1'b0;
    unique case (modeField)
      MODE_COMPARE: next_pinLevel = compareLevel ^ polarityBit;
      MODE_PWM: begin
        unique case (pinFunction)
          PF_INACTIVE: next_pinLevel = !outputControl;
          PF_ACTIVE:   next_pinLevel = outputControl;
          PF_WAVE:     next_pinLevel = pwmActive ? outputControl : !outputControl;
          PF_SINGLE:   next_pinLevel = pulseOn ? outputControl : !outputControl;
        endcase
        next_pinLevel = next_pinLevel ^ polarityBit;
      end
      MODE_CAPTURE: next_pinLevel = polarityBit;
      MODE_TIMER:   next_pinLevel = 1'b0;
    endcase
  end

  // Registered output pins
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timerOutputPin    <= 1'b0;
      timerOutputPinInv <= 1'b1;
    end else begin
      timerOutputPin    <= next_pinLevel;
      timerOutputPinInv <= !next_pinLevel;
    end
  end

  // hsize is accepted but only byte lane 0 is stored
  logic unusedSize;
  assign unusedSize = ^hsize;

endmodule : stmr_top

// >>> tb/stmr_props.sv
`timescale 1ns/1ps
module stmr_props (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       sys_rst,
  // Bus
  input wire logic                       hsel,
  input wire logic [stmr_pkg::BUS_W-1:0] haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic [stmr_pkg::BUS_W-1:0] hrdata,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  // Pins and events
  input wire logic                       timerOutputPin,
  input wire logic                       timerOutputPinInv,
  input wire logic                       matchAFlag,
  input wire logic                       periodMatchFlag
);
  import stmr_pkg::*;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic taken;
  // Accepted address phase
  assign taken = hsel && hready && htrans[1] && hreadyout;
  sequence sWaitOne;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_ONE_WAIT: assert property (taken |=> sWaitOne)
    else $error("wait state not single");
  AST_OKAY: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  AST_RSV_ZERO: assert property (
    taken && !hwrite && haddr[7:0] == OFS_RUN_CLOCK |-> ##2 hrdata[2:0] == 3'h0)
    else $error("unused control bits read nonzero");
  AST_WR_DATA: assert property (taken && hwrite |-> ##2 hrdata == 32'h0)
    else $error("read data not cleared by write");
  AST_PIN_PAIR: assert property (timerOutputPinInv == !timerOutputPin)
    else $error("output pins not complementary");
  AST_A_PULSE: assert property (matchAFlag |=> !matchAFlag)
    else $error("match flag longer than a cycle");
  AST_P_PULSE: assert property ($rose(periodMatchFlag) |=> $fell(periodMatchFlag))
    else $error("period flag longer than a cycle");
  AST_QUIET_START: assert property (
    $fell(sys_rst) |-> (!matchAFlag && !periodMatchFlag) [*3])
    else $error("event while stopped");
endmodule : stmr_props

// >>> tb/stmr_pin_model.sv
`timescale 1ns/1ps
module stmr_pin_model (
  // Clock
  input wire logic core_clk,
  // Pins towards the timer
  output logic     extPin,
  output logic     capPin,
  output logic     subPin
);
  // Plain input levels, clock still between bursts
  initial begin
    extPin = 1'b0;
    capPin = 1'b0;
    subPin = 1'b0;
  end
  // External clock burst, slow enough for the pin synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge core_clk);
      extPin <= 1'b1;
      repeat (4) @(posedge core_clk);
      extPin <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask : pulse
  // Capture pin pulse, long enough for the pin synchroniser
  task automatic cap();
    @(posedge core_clk);
    capPin <= 1'b1;
    repeat (4) @(posedge core_clk);
    capPin <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : cap
endmodule : stmr_pin_model

// >>> tb/tb_stmr_top.sv
`timescale 1ns/1ps
module tb_stmr_top;
  import stmr_pkg::*;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  logic             core_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             hsel = 1'b0;
  logic             hwrite = 1'b0;
  logic [1:0]       htrans = 2'h0;
  logic [2:0]       hsize = 3'h2;
  logic [BUS_W-1:0] haddr = 32'h0;
  logic [BUS_W-1:0] hwdata = 32'h0;
  logic [BUS_W-1:0] hrdata, rd, held;
  logic             hreadyout, hresp, extPin, capPin, subPin, outPin, matchA, matchP;
  int               err_total = 0;
  int               cmp_count = 0;
  stmr_pin_model pins (.core_clk, .extPin, .capPin, .subPin);
  stmr_top DUT (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .externalClockPin(extPin),
    .capturePin(capPin), .subClockPin(subPin), .timerOutputPin(outPin),
    .timerOutputPinInv(), .matchAFlag(matchA), .periodMatchFlag(matchP));
  // Clock
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp
  task results;
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // Single transfer, ready sampled at the rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0);
    cmp(rd, e, m);
  endtask : rdc
  task t_regs;
    rdc(OFS_RUN_CLOCK, 32'h0, "ctl0 reset");
    rdc(OFS_MODE_OUTPUT, 32'h0, "ctl1 reset");
    bus(1'b1, OFS_RUN_CLOCK, 32'hf7);
    rdc(OFS_RUN_CLOCK, 32'hf0, "unused bits");
    bus(1'b1, OFS_COUNT_LOW, 32'h55);
    rdc(OFS_COUNT_LOW, 32'h0, "count write");
    bus(1'b1, OFS_MATCH_LOW, 32'h34);
    bus(1'b1, OFS_MATCH_HIGH, 32'h12);
    rdc(OFS_MATCH_LOW, 32'h34, "match low");
    rdc(OFS_MATCH_HIGH, 32'h12, "match high");
    rdc(8'h40, 32'h0, "unmapped");
  endtask : t_regs
  task t_period;
    int n;
    bus(1'b1, OFS_MODE_OUTPUT, 32'h0);
    bus(1'b1, OFS_PERIOD, 32'h1);
    bus(1'b1, OFS_RUN_CLOCK, 32'h18);
    do @(negedge core_clk); while (matchP !== 1'b1);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (matchP !== 1'b1);
    cmp(n, 256, "period spacing");
    bus(1'b1, OFS_RUN_CLOCK, 32'h98);
    bus(1'b0, OFS_COUNT_LOW, 32'h0);
    held = rd;
    rdc(OFS_COUNT_LOW, held, "paused");
    bus(1'b1, OFS_RUN_CLOCK, 32'h10);
    rdc(OFS_COUNT_LOW, held, "stopped");
  endtask : t_period
  task t_ext;
    bus(1'b1, OFS_RUN_CLOCK, 32'h68);
    rdc(OFS_COUNT_LOW, 32'h0, "run clear");
    pins.pulse(5);
    rdc(OFS_COUNT_LOW, 32'h5, "rising");
    bus(1'b1, OFS_RUN_CLOCK, 32'h70);
    bus(1'b1, OFS_RUN_CLOCK, 32'h78);
    pins.pulse(3);
    rdc(OFS_COUNT_LOW, 32'h3, "falling");
  endtask : t_ext
  // Compare and pulse modes, each pin function, match A at three
  task t_out;
    logic [7:0] md [8];
    logic [1:0] ex [8];
    md = '{8'h01, 8'h19, 8'h25, 8'h31, 8'h88, 8'h98, 8'ha8, 8'hb8};
    ex = '{2'b00, 2'b10, 2'b10, 2'b01, 2'b00, 2'b11, 2'b10, 2'b10};
    bus(1'b1, OFS_MATCH_LOW, 32'h3);
    bus(1'b1, OFS_MATCH_HIGH, 32'h0);
    foreach (md[i]) begin
      bus(1'b1, OFS_RUN_CLOCK, 32'h60);
      bus(1'b1, OFS_MODE_OUTPUT, {24'h0, md[i]});
      bus(1'b1, OFS_RUN_CLOCK, 32'h68);
      repeat (3) @(negedge core_clk);
      cmp(outPin, ex[i][1], "initial pin");
      pins.pulse(3);
      @(negedge core_clk);
      cmp(outPin, ex[i][0], "pin after match");
      rdc(OFS_COUNT_LOW, md[i][7] ? 32'h3 : 32'h0, "clear select");
    end
  endtask : t_out
  // Capture on a rising capture edge, count two ext ticks
  task t_cap;
    bus(1'b1, OFS_RUN_CLOCK, 32'h60);
    bus(1'b1, OFS_MODE_OUTPUT, 32'h40);
    bus(1'b1, OFS_RUN_CLOCK, 32'h68);
    pins.pulse(2);
    pins.cap();
    rdc(OFS_MATCH_LOW, 32'h2, "capture");
  endtask : t_cap
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_period();
    t_ext();
    t_out();
    t_cap();
    results();
  end
  // Watchdog
  initial begin
    #3000000;
    err_total++;
    results();
  end
endmodule : tb_stmr_top
bind stmr_top stmr_props chk (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .timerOutputPin(timerOutputPin),
  .timerOutputPinInv(timerOutputPinInv), .matchAFlag(matchAFlag),
  .periodMatchFlag(periodMatchFlag));
